// File: design/card_cfg_pkg.sv
// Purpose: shared constants and types for the card configuration register bank
// Assumes: 32-bit Avalon-MM register bus, byte addresses
// Notes:   field positions of the data-register tail follow csd_tail_t
package card_cfg_pkg;

  // ---------------------------------------------------------------
  // register map (byte offsets)
  // ---------------------------------------------------------------
  localparam logic [7:0] OFS_CSD_TAIL = 8'h00; // data-register tail fields
  localparam logic [7:0] OFS_ERASE    = 8'h04; // erase unit size
  localparam logic [7:0] OFS_CFG_LO   = 8'h08; // config reg [31:0]
  localparam logic [7:0] OFS_CFG_HI   = 8'h0C; // config reg [63:32]
  localparam logic [7:0] OFS_STAT     = 8'h10; // card status word
  localparam logic [7:0] OFS_EXT      = 8'h40; // extended status, 16 words
  localparam int         EXT_WORDS    = 16;    // 512 bits

  // ---------------------------------------------------------------
  // data-register tail layout
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [6:0] checksum;                // host maintained
    logic       rsv_hi;                  // reads zero
    logic       transient_lock_flag;     // set and clear
    logic       lasting_lock_flag;       // set only
    logic       copy;                    // set only
    logic [1:0] file_format;             // layout code
    logic       volume_layout_group;     // 1 is reserved
    logic       partial_write_allow;     // small blocks allowed
    logic [3:0] max_write_block_exp;     // mirrors read exponent
    logic [2:0] program_time_multiplier; // log2 of multiple
    logic [1:0] rsv_lo;                  // reads zero
    logic       group_protect_allow;     // group protection offered
    logic [6:0] protect_group_size;      // groups minus one
  } csd_tail_t;

  localparam logic [31:0] CSD_TAIL_RST = 32'h0001_2880; // gpa=1, x4, exp 9
  localparam logic [2:0]  PTM_MAX_CODE = 3'h5;          // 32x, rest reserved
  localparam logic [6:0]  ERASE_RST    = 7'h00;         // one block per sector
  localparam logic [8:0]  UNIT_512_MSK = 9'h1FF;        // 512-byte resolution

  // ---------------------------------------------------------------
  // card configuration register value
  // ---------------------------------------------------------------
  localparam logic [3:0]  CFG_LAYOUT_VER = 4'h0;  // structure 1.0
  localparam logic [3:0]  CFG_SPEC_VER   = 4'h0;  // spec 1.0-1.01
  localparam logic        CFG_ERASED_VAL = 1'b0;  // erased reads 0
  localparam logic [2:0]  CFG_SECURITY   = 3'h2;  // protocol 2.0
  localparam logic [3:0]  CFG_WIDTHS     = 4'h5;  // 1 and 4 lanes
  localparam logic [15:0] CFG_RSV        = 16'h0000;
  localparam logic [31:0] CFG_MFR        = 32'h0000_0000;
  localparam logic [63:0] CFG_VALUE = {CFG_LAYOUT_VER, CFG_SPEC_VER, CFG_ERASED_VAL,
                                       CFG_SECURITY, CFG_WIDTHS, CFG_RSV, CFG_MFR};

  // ---------------------------------------------------------------
  // status word bits and bus states
  // ---------------------------------------------------------------
  localparam int ST_LOCKED = 0; // writes and erases refused
  localparam int ST_COPY   = 1; // non-original
  localparam int ST_OVWR   = 2; // reverse attempt, clear on read

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b00,
    BUS_ACK  = 2'b01
  } bus_state_t;

endpackage : card_cfg_pkg

// File: design/card_config_registers.sv
// Purpose: configuration register bank of a memory card on Avalon-MM
// Assumes: one clock, async active-low reset, master holds request until ack
// Notes:   every access answers in exactly two cycles
//
// The address map and the Avalon-MM slave port were decided locally.
`timescale 1ns/1ps
module card_config_registers #(
  parameter int RD_BLK_EXP = 9, // read block exponent
  parameter bit ROM_CARD   = 0  // layout fields fixed when set
) (
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [7:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic      [31:0] avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic [11:0] wr_len,           // requested write block bytes
  output logic             wr_len_ok_r,      // wr_len acceptable
  output logic             write_erase_en_r, // writes/erases allowed
  output logic             group_protect_r,  // group protection offered
  output logic      [7:0]  protect_groups_r, // erase groups per group
  output logic      [7:0]  sector_blocks_r,  // write blocks per sector
  output logic      [5:0]  program_mult_r,   // program/read time ratio
  output logic      [11:0] write_blk_bytes_r // max write block bytes
);

  // ---------------------------------------------------------------
  // elaboration check
  // ---------------------------------------------------------------
  // only 512..2048 byte blocks are defined
  if (RD_BLK_EXP < 9 || RD_BLK_EXP > 11) begin : g_bad_exp
    $error("RD_BLK_EXP must lie in 9..11");
  end

  localparam logic [3:0] WR_EXP = 4'(RD_BLK_EXP); // mirrored exponent

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------
  // byte-lane merge for partial writes
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        m[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return m;
  endfunction : merge

  // write length acceptance for the given maximum
  function automatic logic len_ok(input logic [11:0] len, input logic [11:0] maxl,
                                  input logic part);
    return (len != 12'h000) && (len <= maxl) &&
           (part || len == maxl || (len[8:0] & package_mask()) == 9'h000);
  endfunction : len_ok

  function automatic logic [8:0] package_mask();
    return card_cfg_pkg::UNIT_512_MSK;
  endfunction : package_mask

  // ---------------------------------------------------------------
  // state
  // ---------------------------------------------------------------
  card_cfg_pkg::bus_state_t  state_r;                        // bus handshake
  card_cfg_pkg::csd_tail_t   tail_r;                         // tail fields
  card_cfg_pkg::csd_tail_t   tail_nxt;                       // after write
  logic [6:0]                erase_size_r;                   // erase unit size
  logic                      ovwr_err_r;                     // sticky error
  logic [31:0]               ext_mem [card_cfg_pkg::EXT_WORDS]; // extended status
  logic [31:0]               rd_mux;                         // read data select
  logic [31:0]               stat_word;                      // status word
  logic                      wr_fire;                        // write commits
  logic                      rd_fire;                        // read completes
  logic                      ext_hit;                        // ext window hit
  logic [3:0]                ext_idx;                        // ext word index
  logic                      rev_try;                        // clear of set-only bit

  assign wr_fire = avs_write && (state_r == card_cfg_pkg::BUS_ACK);
  assign rd_fire = avs_read && (state_r == card_cfg_pkg::BUS_ACK);
  assign ext_hit = avs_address[7:6] == card_cfg_pkg::OFS_EXT[7:6];
  assign ext_idx = avs_address[5:2];

  // ---------------------------------------------------------------
  // bus handshake
  // ---------------------------------------------------------------
  // waitrequest drops for one cycle after a request is seen
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      state_r         <= card_cfg_pkg::BUS_IDLE;
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0000_0000;
    end else begin
      case (state_r)
        card_cfg_pkg::BUS_IDLE: begin
          if (avs_read || avs_write) begin
            state_r         <= card_cfg_pkg::BUS_ACK;
            avs_waitrequest <= 1'b0;
            avs_readdata    <= avs_read ? rd_mux : avs_readdata;
          end
        end
        card_cfg_pkg::BUS_ACK: begin // commit edge, back to waiting
          state_r         <= card_cfg_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
        default: begin
          state_r         <= card_cfg_pkg::BUS_IDLE;
          avs_waitrequest <= 1'b1;
        end
      endcase
    end
  end

  // ---------------------------------------------------------------
  // read decode
  // ---------------------------------------------------------------
  assign stat_word = {29'h0, ovwr_err_r, tail_r.copy,
                      tail_r.lasting_lock_flag | tail_r.transient_lock_flag};

  // unmapped offsets read zero
  always_comb begin
    rd_mux = 32'h0000_0000;
    if (ext_hit) begin
      rd_mux = ext_mem[ext_idx];
    end else begin
      case (avs_address)
        card_cfg_pkg::OFS_CSD_TAIL: begin
          rd_mux = tail_r;
          rd_mux[16:13] = WR_EXP;
        end
        card_cfg_pkg::OFS_ERASE:  rd_mux = {25'h0, erase_size_r};
        card_cfg_pkg::OFS_CFG_LO: rd_mux = card_cfg_pkg::CFG_VALUE[31:0];
        card_cfg_pkg::OFS_CFG_HI: rd_mux = card_cfg_pkg::CFG_VALUE[63:32];
        card_cfg_pkg::OFS_STAT:   rd_mux = stat_word;
        default:                  rd_mux = 32'h0000_0000;
      endcase
    end
  end

  // ---------------------------------------------------------------
  // tail field update
  // ---------------------------------------------------------------
  always_comb begin
    tail_nxt = merge(tail_r, avs_writedata, avs_byteenable);
    if (tail_nxt.program_time_multiplier > card_cfg_pkg::PTM_MAX_CODE) begin
      tail_nxt.program_time_multiplier = tail_r.program_time_multiplier;
    end
    if (ROM_CARD || tail_nxt.volume_layout_group) begin
      tail_nxt.volume_layout_group = tail_r.volume_layout_group;
      tail_nxt.file_format         = tail_r.file_format;
    end
    tail_nxt.copy = tail_nxt.copy | tail_r.copy;
    tail_nxt.lasting_lock_flag = tail_nxt.lasting_lock_flag | tail_r.lasting_lock_flag;
    tail_nxt.max_write_block_exp = tail_r.max_write_block_exp;
    tail_nxt.rsv_hi = 1'b0;
    tail_nxt.rsv_lo = 2'b00;
  end

  // attempt to clear a set-only bit
  assign rev_try = wr_fire && (avs_address == card_cfg_pkg::OFS_CSD_TAIL) &&
                   ((tail_r.copy && avs_byteenable[2] && !avs_writedata[21]) ||
                    (tail_r.lasting_lock_flag && avs_byteenable[2] && !avs_writedata[22]));

  // tail register; the checksum is stored exactly as the host writes it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      tail_r <= card_cfg_pkg::CSD_TAIL_RST;
    end else if (wr_fire && avs_address == card_cfg_pkg::OFS_CSD_TAIL) begin
      tail_r <= tail_nxt;
    end
  end

  // erase unit size register
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      erase_size_r <= card_cfg_pkg::ERASE_RST;
    end else if (wr_fire && avs_address == card_cfg_pkg::OFS_ERASE &&
                 avs_byteenable[0]) begin
      erase_size_r <= avs_writedata[6:0];
    end
  end

  // sticky error; a new attempt wins over the read that clears it
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ovwr_err_r <= 1'b0;
    end else if (rev_try) begin
      ovwr_err_r <= 1'b1;
    end else if (rd_fire && avs_address == card_cfg_pkg::OFS_STAT) begin
      ovwr_err_r <= 1'b0;
    end
  end

  // extended status words, filled by card firmware over the bus
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      for (int i = 0; i < card_cfg_pkg::EXT_WORDS; i++) begin
        ext_mem[i] <= 32'h0000_0000;
      end
    end else if (wr_fire && ext_hit) begin
      ext_mem[ext_idx] <= merge(ext_mem[ext_idx], avs_writedata, avs_byteenable);
    end
  end

  // ---------------------------------------------------------------
  // derived outputs, one cycle behind the fields
  // ---------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      wr_len_ok_r       <= 1'b0;
      write_erase_en_r  <= 1'b0;
      group_protect_r   <= 1'b0;
      protect_groups_r  <= 8'h01;
      sector_blocks_r   <= 8'h01;
      program_mult_r    <= 6'h01;
      write_blk_bytes_r <= 12'h200;
    end else begin
      wr_len_ok_r <= len_ok(wr_len, 12'(1 << RD_BLK_EXP), tail_r.partial_write_allow);
      write_erase_en_r <= !(tail_r.lasting_lock_flag || tail_r.transient_lock_flag);
      group_protect_r  <= tail_r.group_protect_allow;
      protect_groups_r <= {1'b0, tail_r.protect_group_size} + 8'h01;
      sector_blocks_r  <= {1'b0, erase_size_r} + 8'h01;
      program_mult_r   <= 6'(1 << tail_r.program_time_multiplier);
      write_blk_bytes_r <= 12'(1 << RD_BLK_EXP);
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);

  sequence s_req;
    (avs_read || avs_write) && state_r == card_cfg_pkg::BUS_IDLE;
  endsequence
  sequence s_ack;
    !avs_waitrequest ##1 avs_waitrequest;
  endsequence

  property p_bus_two;
    s_req |=> s_ack;
  endproperty
  a_bus_two: assert property (p_bus_two) else $error("ack not one cycle after request");

  property p_cfg_hi;
    s_req and (avs_read && avs_address == card_cfg_pkg::OFS_CFG_HI) |=>
      avs_readdata == 32'h0025_0000;
  endproperty
  a_cfg_hi: assert property (p_cfg_hi) else $error("config high word wrong");

  property p_cfg_ro;
    s_req and (avs_read && avs_address == card_cfg_pkg::OFS_CFG_LO) |=>
      avs_readdata == 32'h0000_0000;
  endproperty
  a_cfg_ro: assert property (p_cfg_ro) else $error("config low word changed");

  property p_copy_sticky;
    tail_r.copy |=> tail_r.copy [*3];
  endproperty
  a_copy_sticky: assert property (p_copy_sticky) else $error("copy flag cleared");

  property p_lock_gate;
    tail_r.lasting_lock_flag |=> !write_erase_en_r && tail_r.lasting_lock_flag;
  endproperty
  a_lock_gate: assert property (p_lock_gate) else $error("lasting lock lost");

  property p_tmp_gate;
    $fell(tail_r.transient_lock_flag) && !tail_r.lasting_lock_flag |=> write_erase_en_r;
  endproperty
  a_tmp_gate: assert property (p_tmp_gate) else $error("transient lock not released");

  property p_groups;
    protect_groups_r == {1'b0, $past(tail_r.protect_group_size)} + 8'h01;
  endproperty
  a_groups: assert property (p_groups) else $error("group count not size plus one");

  property p_ptm;
    tail_r.program_time_multiplier <= card_cfg_pkg::PTM_MAX_CODE;
  endproperty
  a_ptm: assert property (p_ptm) else $error("reserved multiplier code stored");

  property p_blk;
    rstn |=> write_blk_bytes_r == 12'(1 << RD_BLK_EXP) && write_blk_bytes_r >= 12'h200;
  endproperty
  a_blk: assert property (p_blk) else $error("write block length wrong");

endmodule : card_config_registers

// File: dv/host_bus_model.sv
// Purpose: host controller model, issues register accesses
// Assumes: Avalon-MM slave lowers waitrequest for one cycle per access
// Notes:   released address, data and byte-enable lines carry inverted last values; read and write strobes go low
`timescale 1ns/1ps
module host_bus_model (
  input  wire logic        clk_sys,
  output logic      [7:0]  avs_address,
  output logic             avs_read,
  output logic             avs_write,
  output logic      [31:0] avs_writedata,
  output logic      [3:0]  avs_byteenable,
  input  wire logic [31:0] avs_readdata,
  input  wire logic        avs_waitrequest
);
  // ---------------------------------------------------------------
  // bus master
  // ---------------------------------------------------------------
  // quiet bus until the first access
  initial begin
    avs_address    = 8'h00;
    avs_read       = 1'b0;
    avs_write      = 1'b0;
    avs_writedata  = 32'h0000_0000;
    avs_byteenable = 4'h0;
  end

  // one access; the leading edge keeps back-to-back calls off one time step
  task automatic bus_access(input logic wr, input logic [7:0] addr, input logic [31:0] data,
                            input logic [3:0] be, output logic [31:0] rdata);
    @(posedge clk_sys);
    avs_address    <= addr;
    avs_write      <= wr;
    avs_read       <= !wr;
    avs_writedata  <= data;
    avs_byteenable <= be;
    // request held until waitrequest is seen low at an edge
    do @(posedge clk_sys); while (avs_waitrequest !== 1'b0);
    rdata = avs_readdata;
    avs_read       <= 1'b0;
    avs_write      <= 1'b0;
    avs_address    <= ~addr;
    avs_writedata  <= ~data;
    avs_byteenable <= ~be;
  endtask : bus_access
endmodule : host_bus_model

// File: dv/test_card_config_registers.sv
// Purpose: self-checking bench of the card configuration register bank
// Assumes: host model drives the register bus, bench drives wr_len
// Notes:   read exponent set to 11 so length checks run against a 2048-byte maximum, from 0 up to 2560
`timescale 1ns/1ps
module test_card_config_registers;
  // ---------------------------------------------------------------
  // signals
  // ---------------------------------------------------------------
  logic        clk_sys;  // 40 MHz
  logic        rstn;     // async reset
  logic [7:0]  adr;      // bus address
  logic        rd_s;     // read strobe
  logic        wr_s;     // write strobe
  logic [31:0] wdat;     // write data
  logic [3:0]  be;       // byte lanes
  logic [31:0] rdat;     // read data
  logic        wait_s;   // waitrequest
  logic [11:0] wr_len;   // requested length
  logic        len_ok;   // length verdict
  logic        we_en;    // writes allowed
  logic        gp;       // group protection
  logic [7:0]  pgroups;  // groups per protect group
  logic [7:0]  sect;     // blocks per sector
  logic [5:0]  mult;     // program multiple
  logic [11:0] blk;      // write block bytes
  logic [31:0] rd;       // scratch read data
  int          err_total;
  int          num_checks;
  card_cfg_pkg::csd_tail_t t; // expected tail contents
  card_cfg_pkg::csd_tail_t w; // word actually written

  always #12.5 clk_sys = ~clk_sys;

  host_bus_model host_bus_model_i (.clk_sys(clk_sys), .avs_address(adr), .avs_read(rd_s),
    .avs_write(wr_s), .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat),
    .avs_waitrequest(wait_s));

  card_config_registers #(.RD_BLK_EXP(11), .ROM_CARD(0)) card_config_registers_i (
    .clk_sys(clk_sys), .rstn(rstn), .avs_address(adr), .avs_read(rd_s), .avs_write(wr_s),
    .avs_writedata(wdat), .avs_byteenable(be), .avs_readdata(rdat), .avs_waitrequest(wait_s),
    .wr_len(wr_len), .wr_len_ok_r(len_ok), .write_erase_en_r(we_en), .group_protect_r(gp),
    .protect_groups_r(pgroups), .sector_blocks_r(sect), .program_mult_r(mult),
    .write_blk_bytes_r(blk));

  // ---------------------------------------------------------------
  // tasks
  // ---------------------------------------------------------------
  task end_of_test;
    $display("checks %0d mismatches %0d", num_checks, err_total);
    if (err_total == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : end_of_test

  // bus read data against expectation
  task chk_rd(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_rd

  // derived port output against expectation
  task chk_out(input string name, input logic [11:0] exp, input logic [11:0] got);
    num_checks++;
    if (got !== exp) begin
      err_total++;
      $display("BAD %s expected %h seen %h", name, exp, got);
    end
  endtask : chk_out

  // derived outputs lag the register by one edge
  task settle;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask : settle

  task wr(input logic [7:0] a, input logic [31:0] d);
    host_bus_model_i.bus_access(1'b1, a, d, 4'hF, rd);
  endtask : wr

  task rd_chk(input string name, input logic [7:0] a, input logic [31:0] exp);
    host_bus_model_i.bus_access(1'b0, a, 32'h0000_0000, 4'hF, rd);
    chk_rd(name, exp, rd);
  endtask : rd_chk

  task wr_tail(input card_cfg_pkg::csd_tail_t v);
    v.checksum = 7'(v[24:0] % 25'h7F);
    t.checksum = v.checksum;
    wr(card_cfg_pkg::OFS_CSD_TAIL, v);
    settle;
  endtask : wr_tail

  task len_case(input logic part, input logic [11:0] len, input logic ok);
    t.partial_write_allow = part;
    wr_tail(t);
    @(posedge clk_sys);
    wr_len <= len;
    settle;
    chk_out("len_ok", {11'h000, ok}, {11'h000, len_ok});
  endtask : len_case

  // ---------------------------------------------------------------
  // watchdog and main sequence
  // ---------------------------------------------------------------
  initial begin
    #125000;
    err_total++;
    end_of_test;
  end

  initial begin
    clk_sys = 1'b0;
    rstn = 1'b0;
    wr_len = 12'h200;
    err_total = 0;
    num_checks = 0;
    t = card_cfg_pkg::CSD_TAIL_RST;
    t.max_write_block_exp = 4'hB;
    repeat (8) @(posedge clk_sys);
    rstn <= 1'b1;
    settle;
    chk_out("we_en", 12'h001, {11'h000, we_en});
    chk_out("blk", 12'h800, blk);
    chk_out("pgroups", 12'h001, {4'h0, pgroups});
    chk_out("gp", 12'h001, {11'h000, gp});
    chk_out("len_ok", 12'h001, {11'h000, len_ok});
    rd_chk("tail", card_cfg_pkg::OFS_CSD_TAIL, t);
    rd_chk("cfg_lo", card_cfg_pkg::OFS_CFG_LO, 32'h0000_0000);
    rd_chk("cfg_hi", card_cfg_pkg::OFS_CFG_HI, {4'h0, 4'h0, 1'b0, 3'h2, 4'h5, 16'h0000});
    wr(card_cfg_pkg::OFS_CFG_LO, 32'hFFFF_FFFF);
    wr(card_cfg_pkg::OFS_CFG_HI, 32'hFFFF_FFFF);
    rd_chk("cfg_lo", card_cfg_pkg::OFS_CFG_LO, 32'h0000_0000);
    rd_chk("cfg_hi", card_cfg_pkg::OFS_CFG_HI, 32'h0025_0000);
    t.protect_group_size = 7'h7F;
    wr_tail(t);
    chk_out("pgroups", 12'h080, {4'h0, pgroups});
    // low lane only: size and allow bit cleared, rest kept
    host_bus_model_i.bus_access(1'b1, card_cfg_pkg::OFS_CSD_TAIL, 32'h0000_0000, 4'h1, rd);
    t.protect_group_size = 7'h00;
    t.group_protect_allow = 1'b0;
    settle;
    chk_out("pgroups", 12'h001, {4'h0, pgroups});
    chk_out("gp", 12'h000, {11'h000, gp});
    wr(card_cfg_pkg::OFS_ERASE, 32'h0000_007F);
    settle;
    chk_out("sect", 12'h080, {4'h0, sect});
    for (int c = 0; c < 6; c++) begin
      t.program_time_multiplier = 3'(c);
      wr_tail(t);
      chk_out("mult", 12'(1 << c), {6'h00, mult});
    end
    w = t;
    w.program_time_multiplier = 3'h6;
    w.max_write_block_exp = 4'h9;
    wr_tail(w);
    chk_out("mult", 12'h020, {6'h00, mult});
    rd_chk("tail", card_cfg_pkg::OFS_CSD_TAIL, t);
    len_case(1'b0, 12'h800, 1'b1);
    len_case(1'b0, 12'h600, 1'b1);
    len_case(1'b0, 12'h200, 1'b1);
    len_case(1'b0, 12'h3E8, 1'b0);
    len_case(1'b0, 12'hA00, 1'b0);
    len_case(1'b1, 12'h001, 1'b1);
    len_case(1'b1, 12'h801, 1'b0);
    len_case(1'b1, 12'h000, 1'b0);
    for (int f = 0; f < 4; f++) begin
      t.file_format = 2'(f);
      wr_tail(t);
      rd_chk("tail", card_cfg_pkg::OFS_CSD_TAIL, t);
    end
    w = t;
    w.volume_layout_group = 1'b1;
    w.file_format = 2'h0;
    wr_tail(w);
    rd_chk("tail", card_cfg_pkg::OFS_CSD_TAIL, t);
    t.copy = 1'b1;
    wr_tail(t);
    w = t;
    w.copy = 1'b0;
    wr_tail(w);
    rd_chk("tail", card_cfg_pkg::OFS_CSD_TAIL, t);
    rd_chk("status", card_cfg_pkg::OFS_STAT, 32'h0000_0006);
    rd_chk("status", card_cfg_pkg::OFS_STAT, 32'h0000_0002);
    t.transient_lock_flag = 1'b1;
    wr_tail(t);
    chk_out("we_en", 12'h000, {11'h000, we_en});
    t.transient_lock_flag = 1'b0;
    wr_tail(t);
    chk_out("we_en", 12'h001, {11'h000, we_en});
    t.lasting_lock_flag = 1'b1;
    wr_tail(t);
    w = t;
    w.lasting_lock_flag = 1'b0;
    wr_tail(w);
    chk_out("we_en", 12'h000, {11'h000, we_en});
    rd_chk("status", card_cfg_pkg::OFS_STAT, 32'h0000_0007);
    wr(card_cfg_pkg::OFS_EXT, 32'hA5A5_5A5A);
    wr(card_cfg_pkg::OFS_EXT + 8'h3C, 32'h1234_5678);
    wr(8'h20, 32'hFFFF_FFFF);
    rd_chk("ext0", card_cfg_pkg::OFS_EXT, 32'hA5A5_5A5A);
    rd_chk("ext15", card_cfg_pkg::OFS_EXT + 8'h3C, 32'h1234_5678);
    rd_chk("unmapped", 8'h20, 32'h0000_0000);
    end_of_test;
  end
endmodule : test_card_config_registers
